// >>> design/fast_diff_serial_band.sv
// Overview of operation
// - Band runs either forwarded-clock or recovery mode
// - Receive factor limited to 1-12,14,16,18,20
// - Word width 4,7,8,9-12,14,16,18,20, independent
// - Bit clock shifts register, words leave slower
// - Lane carries up to 840 Mbps with clock
// - Each receive lane owns a clock recovery unit
// - Two dedicated multipliers make the bit strobes
// - Reference clock reaches only the multipliers
// - Large part 18 lanes each way, small 8
// - Recovery mode words synchronised, bypass optional
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fast_diff_serial_band
  import serdes_pkg::*;
#(
  parameter int NUM_LANES = 18
) (
  input wire logic aclk,                          // Core clock
  input wire logic aresetn,                       // Sync reset, active low
  input wire logic serial_ref_clock_a,            // Forwarded/ref clock
  input wire logic [ADDR_W-1:0] s_axi_awaddr,     // Write address
  input wire logic s_axi_awvalid,                 // Write address valid
  output logic s_axi_awready,                     // Write address ready
  input wire logic [31:0] s_axi_wdata,            // Write data
  input wire logic [3:0] s_axi_wstrb,             // Byte enables
  input wire logic s_axi_wvalid,                  // Write data valid
  output logic s_axi_wready,                      // Write data ready
  output logic [1:0] s_axi_bresp,                 // Write response
  output logic s_axi_bvalid,                      // Write response valid
  input wire logic s_axi_bready,                  // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,     // Read address
  input wire logic s_axi_arvalid,                 // Read address valid
  output logic s_axi_arready,                     // Read address ready
  output logic [31:0] s_axi_rdata,                // Read data
  output logic [1:0] s_axi_rresp,                 // Read response
  output logic s_axi_rvalid,                      // Read data valid
  input wire logic s_axi_rready,                  // Read data ready
  input wire logic [NUM_LANES-1:0] rx_serial,     // Receive pins
  output logic [NUM_LANES*WORD_MAX-1:0] rx_word,  // Received words
  output logic [NUM_LANES-1:0] rx_valid,          // Word present
  input wire logic [NUM_LANES-1:0] rx_ready,      // Core takes word
  input wire logic [NUM_LANES*WORD_MAX-1:0] tx_word, // Words to send
  input wire logic [NUM_LANES-1:0] tx_valid,      // Word offered
  output logic [NUM_LANES-1:0] tx_ready,          // Lane takes word
  output logic [NUM_LANES-1:0] tx_serial          // Transmit pins
);
  lane_ctl_if ctl_if ();  // Settings shared by every lane

  // Link domain: reset synchroniser and a toggle per reference period
  logic [1:0] link_rst_ff;  // Reset seen on the reference clock
  logic ref_tgl_ff, nxt_ref_tgl;

  // Core domain: reference crossing and period measurement
  logic [SYNC_STAGES-1:0] ref_sync_ff;  // Three-stage crossing
  logic ref_lvl_ff, nxt_ref_lvl;        // Accepted toggle level
  logic ref_edge_ff, nxt_ref_edge;      // Pulse per period
  logic [PER_W-1:0] cnt_ff, nxt_cnt;    // Cycles since last edge
  logic [PER_W-1:0] period_ff, nxt_period;
  logic [PER_W:0] tx_acc_ff, nxt_tx_acc;
  logic tx_tick_ff, nxt_tx_tick;
  logic [PER_W:0] tx_sum;

  // Register file
  logic cdr_ff, nxt_cdr;
  logic byp_ff, nxt_byp;
  logic en_ff, nxt_en;
  logic [4:0] rx_mult_ff, nxt_rx_mult;
  logic [4:0] tx_mult_ff, nxt_tx_mult;
  logic [4:0] width_ff, nxt_width;
  logic rej_ff, nxt_rej;                 // Last setting write refused
  logic [NUM_LANES-1:0] ovf_ff, nxt_ovf; // Sticky lost-word flags
  logic [NUM_LANES-1:0] lane_ovf;        // Lost-word pulses

  // AXI slave state
  logic aw_hold_ff, nxt_aw_hold;
  logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_hold_ff, nxt_w_hold;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic do_write;
  logic [31:0] wbits;
  logic aresetn_q;  // Reset seen one edge late

  // Only a toggle leaves this domain; the clock never drives core logic
  always_comb begin
    nxt_ref_tgl = link_rst_ff[1] ? ~ref_tgl_ff : 1'b0;
  end

  // Link-side registers on the reference clock itself
  always_ff @(posedge serial_ref_clock_a) begin
    link_rst_ff <= {link_rst_ff[0], aresetn};
    ref_tgl_ff <= nxt_ref_tgl;
  end

  // Crossing chain; stage one is read by stage two only
  always_ff @(posedge aclk) begin
    if (!aresetn) ref_sync_ff <= '0;
    else ref_sync_ff <= {ref_sync_ff[SYNC_STAGES-2:0], ref_tgl_ff};
  end

  // Period measurement and transmit multiplier
  always_comb begin
    nxt_ref_lvl = ref_lvl_ff;
    nxt_ref_edge = 1'b0;
    if (ref_sync_ff[1] == ref_sync_ff[2]) begin
      nxt_ref_lvl = ref_sync_ff[2];
      nxt_ref_edge = ref_sync_ff[2] != ref_lvl_ff;
    end
    nxt_cnt = (cnt_ff == PER_SAT) ? cnt_ff : cnt_ff + 16'h0001;
    nxt_period = period_ff;
    if (ref_edge_ff) begin
      nxt_cnt = 16'h0001;
      nxt_period = cnt_ff;  // Whole reference period in aclk cycles
    end else if (cnt_ff == PER_SAT) begin
      nxt_period = '0;  // Clock stopped: drop lock
    end
    // Phase accumulator: adding the factor and wrapping at the period
    // yields one tick fewer than the factor per reference period, the realign cycle adding nothing. Limited to one tick
    // per aclk, so bit rate tops out at the core clock.
    tx_sum = tx_acc_ff + {{(PER_W-4){1'b0}}, tx_mult_ff};
    nxt_tx_tick = 1'b0;
    if (!en_ff || period_ff == '0) begin
      nxt_tx_acc = '0;
    end else if (ref_edge_ff) begin
      nxt_tx_acc = '0;  // Realign bit phase to the reference
    end else if (tx_sum >= {1'b0, period_ff}) begin
      nxt_tx_acc = tx_sum - {1'b0, period_ff};
      nxt_tx_tick = 1'b1;
    end else begin
      nxt_tx_acc = tx_sum;
    end
  end

  // Measurement registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_lvl_ff <= 1'b0;
      ref_edge_ff <= 1'b0;
      cnt_ff <= '0;
      period_ff <= '0;
      tx_acc_ff <= '0;
      tx_tick_ff <= 1'b0;
    end else begin
      ref_lvl_ff <= nxt_ref_lvl;
      ref_edge_ff <= nxt_ref_edge;
      cnt_ff <= nxt_cnt;
      period_ff <= nxt_period;
      tx_acc_ff <= nxt_tx_acc;
      tx_tick_ff <= nxt_tx_tick;
    end
  end

  // Settings handed to every lane
  assign ctl_if.period = period_ff;
  assign ctl_if.rx_mult = rx_mult_ff;
  assign ctl_if.width = width_ff;
  assign ctl_if.cdr = cdr_ff;
  assign ctl_if.bypass = byp_ff;
  assign ctl_if.enable = en_ff;
  assign ctl_if.ref_edge = ref_edge_ff;
  assign ctl_if.tx_tick = tx_tick_ff;

  // One receive and one transmit lane per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
      rx_lane u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctl(ctl_if),
        .serial_in(rx_serial[gi]),
        .word_out(rx_word[gi*WORD_MAX +: WORD_MAX]),
        .word_valid(rx_valid[gi]),
        .word_ready(rx_ready[gi]),
        .overflow(lane_ovf[gi])
      );
      tx_lane u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctl(ctl_if),
        .word_in(tx_word[gi*WORD_MAX +: WORD_MAX]),
        .word_valid(tx_valid[gi]),
        .word_ready(tx_ready[gi]),
        .serial_out(tx_serial[gi])
      );
    end
  endgenerate

  // AXI write/read handling and register updates
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_hold = w_hold_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_cdr = cdr_ff;
    nxt_byp = byp_ff;
    nxt_en = en_ff;
    nxt_rx_mult = rx_mult_ff;
    nxt_tx_mult = tx_mult_ff;
    nxt_width = width_ff;
    nxt_rej = rej_ff;
    nxt_ovf = ovf_ff;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid && !aw_hold_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_ff) begin
      nxt_w_hold = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    // Beats stay held, readies low, until the answer is taken
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
    end
    do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    wbits = w_data_ff & {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                         {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    if (do_write) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      case (aw_addr_ff)
        REG_CTRL: begin
          if (w_strb_ff[0]) begin
            nxt_cdr = w_data_ff[CTRL_CDR_BIT];
            nxt_byp = w_data_ff[CTRL_BYP_BIT];
            nxt_en = w_data_ff[CTRL_EN_BIT];
          end
        end
        REG_RX_MULT: begin
          if (w_strb_ff[0]) begin
            nxt_rej = !legal_mult(w_data_ff[4:0]);
            if (legal_mult(w_data_ff[4:0])) nxt_rx_mult = w_data_ff[4:0];
          end
        end
        REG_TX_MULT: begin
          if (w_strb_ff[0]) begin
            nxt_rej = !legal_mult(w_data_ff[4:0]);
            if (legal_mult(w_data_ff[4:0])) nxt_tx_mult = w_data_ff[4:0];
          end
        end
        REG_WIDTH: begin
          if (w_strb_ff[0]) begin
            nxt_rej = !legal_width(w_data_ff[4:0]);
            if (legal_width(w_data_ff[4:0])) nxt_width = w_data_ff[4:0];
          end
        end
        REG_STATUS: begin
          // Read-only; write accepted and ignored
        end
        REG_OVERFLOW: begin
          nxt_ovf = ovf_ff & ~wbits[NUM_LANES-1:0];  // Write one to clear
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end
    // A new loss wins over a clear in the same cycle
    nxt_ovf = nxt_ovf | lane_ovf;
    // Read side: one outstanding read, answer the cycle after address
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) nxt_rvalid = 1'b0;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        REG_CTRL: begin
          nxt_rdata[CTRL_CDR_BIT] = cdr_ff;
          nxt_rdata[CTRL_BYP_BIT] = byp_ff;
          nxt_rdata[CTRL_EN_BIT] = en_ff;
        end
        REG_RX_MULT: nxt_rdata[4:0] = rx_mult_ff;
        REG_TX_MULT: nxt_rdata[4:0] = tx_mult_ff;
        REG_WIDTH: nxt_rdata[4:0] = width_ff;
        REG_STATUS: begin
          nxt_rdata[PER_W-1:0] = period_ff;
          nxt_rdata[STAT_LOCK_BIT] = period_ff != '0;
          nxt_rdata[STAT_REJ_BIT] = rej_ff;
        end
        REG_OVERFLOW: nxt_rdata[NUM_LANES-1:0] = ovf_ff;
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  // Bus and register file registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      cdr_ff <= 1'b0;
      byp_ff <= 1'b0;
      en_ff <= 1'b0;
      rx_mult_ff <= RX_MULT_RST;
      tx_mult_ff <= TX_MULT_RST;
      width_ff <= WIDTH_RST;
      rej_ff <= 1'b0;
      ovf_ff <= '0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      aw_addr_ff <= nxt_aw_addr;
      w_hold_ff <= nxt_w_hold;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      cdr_ff <= nxt_cdr;
      byp_ff <= nxt_byp;
      en_ff <= nxt_en;
      rx_mult_ff <= nxt_rx_mult;
      tx_mult_ff <= nxt_tx_mult;
      width_ff <= nxt_width;
      rej_ff <= nxt_rej;
      ovf_ff <= nxt_ovf;
    end
  end

  // Ready stays low while a captured beat waits
  assign s_axi_awready = !aw_hold_ff && aresetn_q;
  assign s_axi_wready = !w_hold_ff && aresetn_q;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Readiness held off for the cycle after reset
  always_ff @(posedge aclk) begin
    aresetn_q <= aresetn;
  end
endmodule : fast_diff_serial_band
`default_nettype wire

// >>> pkg/serdes_pkg.sv
package serdes_pkg;
  // Structure sizes
  localparam int WORD_MAX = 20;   // Widest parallel word
  localparam int FAC_W = 5;       // Width of factor and word-width fields
  localparam int PER_W = 16;      // Width of measured reference period
  localparam int ADDR_W = 8;      // Decoded AXI address bits
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RX_MULT = 8'h04;
  localparam logic [7:0] REG_TX_MULT = 8'h08;
  localparam logic [7:0] REG_WIDTH = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_OVERFLOW = 8'h14;
  // Control field positions
  localparam int CTRL_CDR_BIT = 0;
  localparam int CTRL_BYP_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  // Status field positions
  localparam int STAT_LOCK_BIT = 16;
  localparam int STAT_REJ_BIT = 17;
  // Values after reset
  localparam logic [4:0] RX_MULT_RST = 5'h0A;
  localparam logic [4:0] TX_MULT_RST = 5'h0A;
  localparam logic [4:0] WIDTH_RST = 5'h0A;
  // Cycle counts
  localparam int SYNC_STAGES = 3;                 // Reference crossing depth
  localparam logic [15:0] PER_SAT = 16'hFFFF;     // Period counter ceiling
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Factors that the band accepts
  function automatic logic legal_mult(input logic [4:0] v);
    legal_mult = (v >= 5'h01 && v <= 5'h0C) || v == 5'h0E || v == 5'h10
                 || v == 5'h12 || v == 5'h14;
  endfunction : legal_mult

  // Word widths the band accepts
  function automatic logic legal_width(input logic [4:0] v);
    legal_width = v == 5'h04 || v == 5'h07 || (v >= 5'h08 && v <= 5'h0C)
                  || v == 5'h0E || v == 5'h10 || v == 5'h12 || v == 5'h14;
  endfunction : legal_width
endpackage : serdes_pkg

// >>> pkg/lane_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lane_ctl_if;
  import serdes_pkg::*;
  logic [PER_W-1:0] period;  // Reference period in aclk cycles
  logic [4:0] rx_mult;       // Receive multiplication factor
  logic [4:0] width;         // Parallel word width
  logic cdr;                 // Clock data recovery mode
  logic bypass;              // Word synchroniser bypassed
  logic enable;              // Band running
  logic ref_edge;            // One pulse per reference clock period
  logic tx_tick;             // Transmit bit strobe
  modport ctl (output period, rx_mult, width, cdr, bypass, enable,
               ref_edge, tx_tick);
  modport lane (input period, rx_mult, width, cdr, bypass, enable,
                ref_edge, tx_tick);
endinterface : lane_ctl_if
`default_nettype wire

// >>> design/rx_lane.sv
`timescale 1ns/1ps
`default_nettype none
module rx_lane
  import serdes_pkg::*;
(
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Sync reset, active low
  lane_ctl_if.lane ctl, // Shared band settings
  input wire logic serial_in, // Serial lane pin
  output logic [WORD_MAX-1:0] word_out, // Deserialised word
  output logic word_valid, // Word present
  input wire logic word_ready, // Core takes word
  output logic overflow // Word lost, one pulse
);
  logic [2:0] sync_ff; // Pin synchroniser chain
  logic din_ff, nxt_din; // Filtered serial level
  logic [PER_W:0] acc_ff, nxt_acc; // Phase accumulator
  logic [WORD_MAX-1:0] sh_ff, nxt_sh; // Serial shift register
  logic [4:0] cnt_ff, nxt_cnt; // Bits gathered so far
  logic [WORD_MAX-1:0] word_ff, nxt_word;
  logic valid_ff, nxt_valid;
  logic ovf_ff, nxt_ovf;
  logic [PER_W:0] sum;
  logic [WORD_MAX-1:0] wmask;
  logic agree, edge_seen, realign, tick, done;

  // Pin synchroniser, stage one feeds stage two only
  always_ff @(posedge aclk) begin
    if (!aresetn) sync_ff <= 3'h0;
    else sync_ff <= {sync_ff[1:0], serial_in};
  end

  // Phase recovery, shifting and word hand-off
  always_comb begin
    agree = sync_ff[1] == sync_ff[2];
    nxt_din = agree ? sync_ff[2] : din_ff;
    edge_seen = agree && (sync_ff[2] != din_ff);
    // Recovery locks to data edges in CDR, else to the forwarded clock
    realign = ctl.cdr ? edge_seen : ctl.ref_edge;
    sum = acc_ff + {{(PER_W-4){1'b0}}, ctl.rx_mult};
    tick = ctl.enable && !realign && ctl.period != '0
           && sum >= {1'b0, ctl.period};
    nxt_acc = acc_ff;
    if (!ctl.enable) nxt_acc = '0;
    else if (realign) nxt_acc = {2'b0, ctl.period[PER_W-1:1]};
    else if (tick) nxt_acc = sum - {1'b0, ctl.period};
    else nxt_acc = sum;
    wmask = (20'h0_0001 << ctl.width) - 20'h0_0001;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    done = 1'b0;
    if (!ctl.enable) begin
      nxt_cnt = '0;
    end else if (tick) begin
      nxt_sh = {sh_ff[WORD_MAX-2:0], din_ff};
      nxt_cnt = cnt_ff + 5'h01;
      if (nxt_cnt >= ctl.width) begin
        nxt_cnt = '0;
        done = 1'b1;
      end
    end
    // Boundary is wherever counting started; core must align words
    nxt_word = word_ff;
    nxt_valid = valid_ff;
    nxt_ovf = 1'b0;
    if (ctl.bypass) begin
      // Bypass: word follows the shifter, valid is a bare pulse
      nxt_valid = done;
      if (done) nxt_word = nxt_sh & wmask;
    end else begin
      if (valid_ff && word_ready) nxt_valid = 1'b0;
      if (done) begin
        if (valid_ff && !word_ready) begin
          nxt_ovf = 1'b1;  // Old word kept, newest dropped
        end else begin
          nxt_word = nxt_sh & wmask;
          nxt_valid = 1'b1;
        end
      end
    end
  end

  // Lane state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_ff <= 1'b0;
      acc_ff <= '0;
      sh_ff <= '0;
      cnt_ff <= '0;
      word_ff <= '0;
      valid_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      din_ff <= nxt_din;
      acc_ff <= nxt_acc;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      word_ff <= nxt_word;
      valid_ff <= nxt_valid;
      ovf_ff <= nxt_ovf;
    end
  end

  assign word_out = word_ff;
  assign word_valid = valid_ff;
  assign overflow = ovf_ff;
endmodule : rx_lane
`default_nettype wire

// >>> design/tx_lane.sv
`timescale 1ns/1ps
`default_nettype none
module tx_lane
  import serdes_pkg::*;
(
  input wire logic aclk,                   // Core clock
  input wire logic aresetn,                // Sync reset, active low
  lane_ctl_if.lane ctl,                    // Shared band settings
  input wire logic [WORD_MAX-1:0] word_in, // Word to send
  input wire logic word_valid,             // Word offered
  output logic word_ready,                 // Shifter empty
  output logic serial_out                  // Serial lane pin
);
  logic [WORD_MAX-1:0] sh_ff, nxt_sh;      // Outgoing bits, MSB of word first
  logic [4:0] left_ff, nxt_left;           // Bits still to send
  logic rdy_ff, nxt_rdy;
  logic out_ff, nxt_out;

  // Load a word when empty, shift one bit per transmit tick
  always_comb begin
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_rdy = rdy_ff;
    nxt_out = out_ff;
    if (!ctl.enable) begin
      nxt_left = '0;
      nxt_rdy = 1'b0;
      nxt_out = 1'b0;
    end else if (rdy_ff && word_valid) begin
      nxt_sh = word_in;
      nxt_left = ctl.width;
      nxt_rdy = 1'b0;
    end else if (ctl.tx_tick) begin
      if (left_ff != '0) begin
        nxt_out = sh_ff[left_ff - 5'h01];
        nxt_left = left_ff - 5'h01;
      end else begin
        nxt_out = 1'b0;  // Idle low when the core has nothing
      end
      nxt_rdy = left_ff <= 5'h01;
    end else if (left_ff == '0) begin
      nxt_rdy = 1'b1;
    end
  end

  // Transmit state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_ff <= '0;
      left_ff <= '0;
      rdy_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      rdy_ff <= nxt_rdy;
      out_ff <= nxt_out;
    end
  end

  assign word_ready = rdy_ff;
  assign serial_out = out_ff;
endmodule : tx_lane
`default_nettype wire

// >>> dv/band_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module band_chk
  import serdes_pkg::*;
#(parameter int NUM_LANES = 1) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_LANES-1:0] tx_valid,
  input wire logic [NUM_LANES-1:0] tx_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write beats taken together
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_b_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_rd_answer: assert property (
    rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_wr_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_wr_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  chk_err_data: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read has data");
  chk_r_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  chk_tx_take: assert property (
    tx_valid[0] && tx_ready[0] |=> !tx_ready[0])
    else $error("tx still ready");
endmodule : band_chk
bind fast_diff_serial_band band_chk #(.NUM_LANES(NUM_LANES)) u_chk (.*);
`default_nettype wire

// >>> dv/remote_link_tx.sv
`timescale 1ns/1ps
`default_nettype none
module remote_link_tx (
  output logic fwd_clk,  // Forwarded clock, free running
  output logic ser_data  // Serial lane, alternating bits
);
  // Data moves on falls; first rise lands inside reset
  initial begin
    fwd_clk = 1'b0;
    ser_data = 1'b0;
    #7;
    forever begin
      fwd_clk = 1'b1;
      #62.5 fwd_clk = 1'b0;
      ser_data = ~ser_data;
      #62.5;
    end
  end
endmodule : remote_link_tx
`default_nettype wire

// >>> dv/fast_diff_serial_band_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fast_diff_serial_band_tb_top;
  import serdes_pkg::*;
  localparam int NUM_LANES = 1;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q;
    logic [1:0] b;} row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_valid, rx_ready, tx_valid, tx_ready, tx_serial;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [WORD_MAX-1:0] rx_word, tx_word;
  wire serial_ref_clock_a;
  wire rx_serial;
  int errors, samples_checked;
  // Write then read back; refused values kept
  row_t rows [9] = '{
    '{REG_CTRL, 32'h0000_0005, 32'h0000_0005, RESP_OKAY},
    '{REG_CTRL, 32'h0000_0007, 32'h0000_0007, RESP_OKAY},
    '{REG_RX_MULT, 32'h0000_0014, 32'h0000_0014, RESP_OKAY},
    '{REG_RX_MULT, 32'h0000_000D, 32'h0000_0014, RESP_OKAY},
    '{REG_TX_MULT, 32'h0000_0001, 32'h0000_0001, RESP_OKAY},
    '{REG_WIDTH, 32'h0000_0005, 32'h0000_000A, RESP_OKAY},
    '{REG_WIDTH, 32'h0000_0004, 32'h0000_0004, RESP_OKAY},
    '{8'h18, 32'h0000_0001, 32'h0000_0000, RESP_SLVERR},
    '{REG_RX_MULT, 32'h0000_0001, 32'h0000_0001, RESP_OKAY}};
  fast_diff_serial_band #(.NUM_LANES(NUM_LANES)) u_dut (.*);
  remote_link_tx u_far (.fwd_clk(serial_ref_clock_a), .ser_data(rx_serial));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d, mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Bounded wait for a level, counted as one comparison
  task automatic wait_lvl(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(s), 32'(v));
  endtask : wait_lvl
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) errors++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) errors++;
  endtask : rd
  initial begin
    errors = 0;
    samples_checked = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, rx_ready, tx_valid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    tx_word = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rsp);
      chk(32'(rsp), 32'(rows[i].b));
      rd(rows[i].a, dat, rsp);
      chk(dat, rows[i].q);
      chk(32'(rsp), 32'(rows[i].b));
    end
    $display("test registers done");
    // Forwarded clock, factor 1, 4-bit words
    wr(REG_CTRL, 32'h0000_0004, rsp);
    rx_ready <= 1'b1;
    wait_lvl(rx_valid, 1'b1);
    // Boundary free: either phase
    chk({31'h0, rx_word[3:0] == 4'hA || rx_word[3:0] == 4'h5}, 1);
    rd(REG_STATUS, dat, rsp);
    chk({31'h0, dat[STAT_LOCK_BIT]}, 32'h0000_0001);
    rx_ready <= 1'b0;
    repeat (120) @(posedge aclk);
    rd(REG_OVERFLOW, dat, rsp);
    chk(dat, 32'h0000_0001);
    rx_ready <= 1'b1;
    wr(REG_OVERFLOW, 32'h0000_0001, rsp);
    rd(REG_OVERFLOW, dat, rsp);
    chk(dat, 32'h0000_0000);
    $display("test receive done");
    tx_word <= 20'h0_000A;
    tx_valid <= 1'b1;
    @(posedge aclk);
    wait_lvl(tx_ready, 1'b1);
    tx_valid <= 1'b0;
    for (int i = 3; i >= 0; i--) wait_lvl(tx_serial, tx_word[i]);
    $display("test transmit done");
    // Spans two link clock edges
    aresetn <= 1'b0;
    repeat (14) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_CTRL, dat, rsp);
    chk(dat, 32'h0000_0000);
    rd(REG_RX_MULT, dat, rsp);
    chk(dat, {27'h0, RX_MULT_RST});
    rd(REG_WIDTH, dat, rsp);
    chk(dat, {27'h0, WIDTH_RST});
    $display("test reset done");
    test_done();
  end
  // Hang guard
  initial begin
    #400us;
    errors++;
    test_done();
  end
endmodule : fast_diff_serial_band_tb_top
`default_nettype wire
